// ==== logic/assess_pkg.sv ====
package assess_pkg;
  // clock and symbol timing
  localparam int CLK_NS = 100;
  localparam int SYMBOL_NS = 16000;
  localparam logic [7:0] SYM_CYCLES = 8'(SYMBOL_NS / CLK_NS);
  localparam logic [3:0] LISTEN_SYMS = 4'h8;
  localparam logic [3:0] AUTO_SYMS = 4'h8;
  localparam logic [3:0] AUTO_SYMS_HR = 4'h2;
  localparam int RESULT_LIMIT_NS = 180000;
  localparam int RESULT_LIMIT_CYCLES = RESULT_LIMIT_NS / CLK_NS;
  // register indices, byte address is index times four
  localparam logic [5:0] IDX_STATUS = 6'h01;
  localparam logic [5:0] IDX_CTRL = 6'h08;
  localparam logic [5:0] IDX_THRES = 6'h09;
  localparam logic [5:0] IDX_SYNC = 6'h15;
  // field positions
  localparam int DONE_BIT = 7;
  localparam int IDLE_BIT = 6;
  localparam int START_BIT = 7;
  localparam int MODE_LSB = 5;
  localparam int CHAN_W = 5;
  localparam int THRES_W = 4;
  localparam int SYNC_DIS_BIT = 7;
  // reset values
  localparam logic [1:0] MODE_RST = 2'h1;
  localparam logic [4:0] CHAN_RST = 5'h0B;
  localparam logic [7:0] THRES_RST = 8'hC7;
  typedef enum logic [1:0] {
    MODE_CS_OR_ED = 2'b00,
    MODE_ED = 2'b01,
    MODE_CS = 2'b10,
    MODE_CS_AND_ED = 2'b11
  } assess_mode_e;
endpackage

// ==== logic/symbol_window.sv ====
`timescale 1ns/1ps
module symbol_window (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic start,
  input wire logic [3:0] n_syms,
  input wire logic [7:0] energy,
  input wire logic carrier,
  output logic running,
  output logic done,
  output logic [7:0] peak,
  output logic cs_seen
);
  logic [7:0] cyc_reg;
  logic [3:0] sym_reg;
  logic [3:0] len_reg;
  logic tick;

  // one-cycle symbol enable from the cycle divider
  assign tick = running && (cyc_reg == assess_pkg::SYM_CYCLES - 8'h01);

  // window timing; the length is latched so a mode change mid-window is harmless
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      running <= 1'b0;
      done <= 1'b0;
      cyc_reg <= 8'h00;
      sym_reg <= 4'h0;
      len_reg <= 4'h0;
    end else if (start) begin
      running <= 1'b1;
      done <= 1'b0;
      cyc_reg <= 8'h00;
      sym_reg <= 4'h0;
      len_reg <= n_syms;
    end else begin
      done <= tick && (sym_reg == len_reg - 4'h1);
      if (tick) begin
        cyc_reg <= 8'h00;
        sym_reg <= sym_reg + 4'h1;
        if (sym_reg == len_reg - 4'h1) begin
          running <= 1'b0;
        end
      end else if (running) begin
        cyc_reg <= cyc_reg + 8'h01;
      end
    end
  end

  // peak energy and carrier seen over the window, held until next start
  always_ff @(posedge sys_clk) begin
    if (rst || start) begin
      peak <= 8'h00;
      cs_seen <= 1'b0;
    end else if (running) begin
      if (energy > peak) begin
        peak <= energy;
      end
      cs_seen <= cs_seen | carrier;
    end
  end
endmodule

// ==== logic/channel_verdict.sv ====
`timescale 1ns/1ps
module channel_verdict (
  input wire logic [1:0] mode,
  input wire logic [7:0] energy,
  input wire logic [3:0] threshold,
  input wire logic carrier,
  output logic idle
);
  logic energy_busy;

  // energy is in 1 dB steps over the floor, threshold in 2 dB steps
  assign energy_busy = energy > {3'h0, threshold, 1'b0};

  // combine energy and carrier sense per algorithm
  always_comb begin
    case (mode)
      assess_pkg::MODE_CS_OR_ED: idle = !(energy_busy || carrier);
      assess_pkg::MODE_ED: idle = !energy_busy;
      assess_pkg::MODE_CS: idle = !carrier;
      assess_pkg::MODE_CS_AND_ED: idle = !(energy_busy && carrier);
      default: idle = 1'b0;
    endcase
  end
endmodule

// ==== logic/channel_assess.sv ====
// The Wishbone slave port was chosen for this implementation.
`timescale 1ns/1ps
// How it works
// - listening check lasts eight symbols, then completes
// - receiving check timing depends on mode, sync
// - modes 1,3,0 wait for automatic measurement end
// - mode 2 or finished measurement answers immediately
// - one automatic measurement per frame after sync
// - sync disable keeps listening; eight-symbol checks
// - status register: done, idle, reserved, radio state
// - done set on completion, cleared by request
// - idle result set on completion, cleared by request
// - start bit self-clears, always reads zero
// - request elsewhere completes without any measurement
// - two-bit algorithm field selects combination
// - energy busy above floor plus 2 dB steps
// - control register also holds channel number
// - listening result within 180 microseconds
module channel_assess (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [4:0] radio_state,
  input wire logic rx_listening,
  input wire logic rx_busy,
  input wire logic sync_hdr_seen,
  input wire logic high_rate,
  input wire logic carrier_sense,
  input wire logic [7:0] energy_level,
  output logic measure_complete_event,
  output logic sync_detect_disable,
  output logic [4:0] radio_channel
);
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LISTEN = 2'b01,
    ST_WAIT_AUTO = 2'b10,
    ST_FINISH = 2'b11
  } assess_state_e;

  assess_state_e state_reg;
  logic [1:0] mode_reg;
  logic [7:0] thres_reg;
  logic start_reg;
  logic done_reg;
  logic idle_reg;
  logic no_meas_reg;
  logic [7:0] eng_reg;
  logic cs_reg;
  logic auto_seen_reg;
  logic auto_used_reg;
  logic [5:0] rd_idx_reg;
  logic [5:0] idx;
  logic wr_en;
  logic listening;
  logic eff_busy;
  logic listen_start;
  logic auto_start;
  logic listen_done;
  logic auto_done;
  logic auto_run;
  logic listen_run;
  logic [7:0] listen_peak;
  logic [7:0] auto_peak;
  logic listen_cs;
  logic auto_cs;
  logic verdict_idle;

  assign idx = wb_adr_i[7:2];
  assign wr_en = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0];

  // the disable bit pins the receiver in listening even mid-frame
  assign listening = rx_listening || (rx_busy && sync_detect_disable);
  assign eff_busy = rx_busy && !sync_detect_disable;
  assign listen_start = start_reg && state_reg == ST_IDLE && listening;
  // a frame gets one automatic measurement only
  assign auto_start = sync_hdr_seen && eff_busy && !auto_used_reg;

  // bus answer: one wait state, ack drops the cycle after it rose
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      rd_idx_reg <= 6'h00;
    end else begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
      rd_idx_reg <= idx;
    end
  end

  // read mux; unmapped offsets answer zero, start bit never reads back
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
      case (idx)
        assess_pkg::IDX_STATUS: wb_dat_o <= {24'h0, done_reg, idle_reg, 1'b0, radio_state};
        assess_pkg::IDX_CTRL: wb_dat_o <= {24'h0, 1'b0, mode_reg, radio_channel};
        assess_pkg::IDX_THRES: wb_dat_o <= {24'h0, thres_reg};
        assess_pkg::IDX_SYNC: wb_dat_o <= {24'h0, sync_detect_disable, 7'h00};
        default: wb_dat_o <= 32'h0000_0000;
      endcase
    end else begin
      wb_dat_o <= 32'h0000_0000;
    end
  end

  // writable fields; channel and mode rewrite on every control write
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      mode_reg <= assess_pkg::MODE_RST;
      radio_channel <= assess_pkg::CHAN_RST;
      thres_reg <= assess_pkg::THRES_RST;
      sync_detect_disable <= 1'b0;
    end else if (wr_en) begin
      if (idx == assess_pkg::IDX_CTRL) begin
        mode_reg <= wb_dat_i[assess_pkg::MODE_LSB +: 2];
        radio_channel <= wb_dat_i[assess_pkg::CHAN_W-1:0];
      end
      if (idx == assess_pkg::IDX_THRES) begin
        thres_reg <= wb_dat_i[7:0];
      end
      if (idx == assess_pkg::IDX_SYNC) begin
        sync_detect_disable <= wb_dat_i[assess_pkg::SYNC_DIS_BIT];
      end
    end
  end

  // start bit is a pulse, nothing stored, so it self-clears
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      start_reg <= 1'b0;
    end else begin
      start_reg <= wr_en && idx == assess_pkg::IDX_CTRL && wb_dat_i[assess_pkg::START_BIT];
    end
  end

  // frame bookkeeping; automatic done seen wins over the frame-end clear
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      auto_used_reg <= 1'b0;
      auto_seen_reg <= 1'b0;
    end else begin
      if (auto_start) begin
        auto_used_reg <= 1'b1;
      end else if (!eff_busy) begin
        auto_used_reg <= 1'b0;
      end
      if (auto_done) begin
        auto_seen_reg <= 1'b1;
      end else if (!eff_busy) begin
        auto_seen_reg <= 1'b0;
      end
    end
  end

  symbol_window u_listen (
    .sys_clk(sys_clk),
    .rst(rst),
    .start(listen_start),
    .n_syms(assess_pkg::LISTEN_SYMS),
    .energy(energy_level),
    .carrier(carrier_sense),
    .running(listen_run),
    .done(listen_done),
    .peak(listen_peak),
    .cs_seen(listen_cs)
  );

  // shorter automatic window in the high-rate modes
  symbol_window u_auto (
    .sys_clk(sys_clk),
    .rst(rst),
    .start(auto_start),
    .n_syms(high_rate ? assess_pkg::AUTO_SYMS_HR : assess_pkg::AUTO_SYMS),
    .energy(energy_level),
    .carrier(carrier_sense),
    .running(auto_run),
    .done(auto_done),
    .peak(auto_peak),
    .cs_seen(auto_cs)
  );

  channel_verdict u_verdict (
    .mode(mode_reg),
    .energy(eng_reg),
    .threshold(thres_reg[assess_pkg::THRES_W-1:0]),
    .carrier(cs_reg),
    .idle(verdict_idle)
  );

  // check sequencing; requests during a running check are ignored
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      eng_reg <= 8'h00;
      cs_reg <= 1'b0;
      no_meas_reg <= 1'b0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (start_reg) begin
            no_meas_reg <= 1'b0;
            if (listening) begin
              state_reg <= ST_LISTEN;
            end else if (eff_busy) begin
              if (mode_reg == assess_pkg::MODE_CS || auto_seen_reg) begin
                eng_reg <= auto_peak;
                cs_reg <= carrier_sense || auto_cs;
                state_reg <= ST_FINISH;
              end else begin
                state_reg <= ST_WAIT_AUTO;
              end
            end else begin
              no_meas_reg <= 1'b1;
              state_reg <= ST_FINISH;
            end
          end
        end
        ST_LISTEN: begin
          if (listen_done) begin
            eng_reg <= listen_peak;
            cs_reg <= listen_cs;
            state_reg <= ST_FINISH;
          end
        end
        ST_WAIT_AUTO: begin
          // a frame that ends early releases the wait with what was seen
          if (auto_done || !eff_busy) begin
            eng_reg <= auto_peak;
            cs_reg <= carrier_sense || auto_cs;
            state_reg <= ST_FINISH;
          end
        end
        ST_FINISH: state_reg <= ST_IDLE;
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // result flags: cleared by a request, set on completion
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      done_reg <= 1'b0;
      idle_reg <= 1'b0;
      measure_complete_event <= 1'b0;
    end else begin
      measure_complete_event <= state_reg == ST_FINISH;
      if (state_reg == ST_FINISH) begin
        done_reg <= 1'b1;
        idle_reg <= verdict_idle && !no_meas_reg;
      end else if (start_reg && state_reg == ST_IDLE) begin
        done_reg <= 1'b0;
        idle_reg <= 1'b0;
      end
    end
  end

  // helper: cycles since an accepted listening request
  logic [11:0] wait_cnt;
  logic listen_pend;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wait_cnt <= 12'h000;
      listen_pend <= 1'b0;
    end else if (listen_start) begin
      wait_cnt <= 12'h001;
      listen_pend <= 1'b1;
    end else if (measure_complete_event) begin
      listen_pend <= 1'b0;
    end else if (listen_pend) begin
      wait_cnt <= wait_cnt + 12'h001;
    end
  end

  property p_listen_len;
    @(posedge sys_clk) disable iff (rst)
      measure_complete_event && listen_pend |-> wait_cnt == 12'd1283; // 1280 window plus 3 stages
  endproperty
  a_listen_len: assert property (p_listen_len)
    else $error("listening check length wrong");

  property p_limit;
    @(posedge sys_clk) disable iff (rst)
      listen_pend |-> wait_cnt <= 12'(assess_pkg::RESULT_LIMIT_CYCLES);
  endproperty
  a_limit: assert property (p_limit)
    else $error("listening result later than limit");

  property p_clear;
    @(posedge sys_clk) disable iff (rst)
      start_reg && state_reg == ST_IDLE |=> !done_reg && !idle_reg;
  endproperty
  a_clear: assert property (p_clear)
    else $error("flags not cleared by request");

  property p_event_done;
    @(posedge sys_clk) disable iff (rst)
      measure_complete_event |-> done_reg && !$past(measure_complete_event);
  endproperty
  a_event_done: assert property (p_event_done)
    else $error("event not single pulse with done");

  property p_immediate;
    @(posedge sys_clk) disable iff (rst)
      start_reg && state_reg == ST_IDLE && eff_busy && !listening
      && (mode_reg == assess_pkg::MODE_CS || auto_seen_reg) |-> ##2 measure_complete_event;
  endproperty
  a_immediate: assert property (p_immediate)
    else $error("immediate result late");

  property p_wait;
    @(posedge sys_clk) disable iff (rst)
      state_reg == ST_WAIT_AUTO && !auto_done && eff_busy |=> state_reg == ST_WAIT_AUTO
      ##1 !measure_complete_event;
  endproperty
  a_wait: assert property (p_wait)
    else $error("result before automatic measurement end");

  property p_once;
    @(posedge sys_clk) disable iff (rst)
      (auto_run || auto_seen_reg) && eff_busy |-> !auto_start;
  endproperty
  a_once: assert property (p_once)
    else $error("second automatic measurement in frame");

  property p_no_meas;
    @(posedge sys_clk) disable iff (rst)
      start_reg && state_reg == ST_IDLE && !listening && !eff_busy
      |-> ##2 measure_complete_event && done_reg && !idle_reg;
  endproperty
  a_no_meas: assert property (p_no_meas)
    else $error("request outside receive did not complete");

  property p_verdict;
    @(posedge sys_clk) disable iff (rst)
      state_reg == ST_FINISH && !no_meas_reg && mode_reg == assess_pkg::MODE_ED
      |=> idle_reg == ($past(eng_reg) <= {3'h0, $past(thres_reg[3:0]), 1'b0});
  endproperty
  a_verdict: assert property (p_verdict)
    else $error("energy verdict wrong");

  property p_start_zero;
    @(posedge sys_clk) disable iff (rst)
      wb_ack_o && rd_idx_reg == assess_pkg::IDX_CTRL |-> !wb_dat_o[assess_pkg::START_BIT];
  endproperty
  a_start_zero: assert property (p_start_zero)
    else $error("start bit read back as one");

  c_listen: cover property (@(posedge sys_clk) listen_pend && measure_complete_event);
  c_wait: cover property (@(posedge sys_clk) state_reg == ST_WAIT_AUTO && auto_done);
  c_immediate: cover property (@(posedge sys_clk)
    start_reg && eff_busy && mode_reg == assess_pkg::MODE_CS);
  c_no_meas: cover property (@(posedge sys_clk) state_reg == ST_FINISH && no_meas_reg);
endmodule

// ==== sim/channel_assess_tb_top.sv ====
`timescale 1ns/1ps
module channel_assess_tb_top;
  typedef struct packed {
    logic [1:0] mode;
    logic [3:0] thr;
    logic [7:0] energy;
    logic cs;
    logic idle;
  } row_s;

  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic [4:0] radio_state = 5'h00;
  logic rx_listening = 1'b0;
  logic rx_busy = 1'b0;
  logic sync_hdr_seen = 1'b0;
  logic high_rate = 1'b0;
  logic carrier_sense = 1'b0;
  logic [7:0] energy_level = 8'h00;
  logic measure_complete_event;
  logic sync_detect_disable;
  logic [4:0] radio_channel;
  int failures = 0;
  int n_checks = 0;
  logic [7:0] q;
  int n;
  // listening cases: busy when energy exceeds twice the threshold
  row_s rows [9] = '{
    '{2'h0, 4'h7, 8'h0A, 1'b0, 1'b1}, '{2'h0, 4'h7, 8'h00, 1'b1, 1'b0},
    '{2'h1, 4'h7, 8'h0F, 1'b0, 1'b0}, '{2'h1, 4'h7, 8'h0E, 1'b1, 1'b1},
    '{2'h2, 4'h0, 8'h32, 1'b0, 1'b1}, '{2'h2, 4'h0, 8'h00, 1'b1, 1'b0},
    '{2'h3, 4'h3, 8'h07, 1'b1, 1'b0}, '{2'h3, 4'h3, 8'h07, 1'b0, 1'b1},
    '{2'h3, 4'hF, 8'h1E, 1'b1, 1'b1}};

  always #50 sys_clk = ~sys_clk;

  channel_assess i_channel_assess (.sys_clk(sys_clk), .rst(rst), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .radio_state(radio_state), .rx_listening(rx_listening), .rx_busy(rx_busy),
    .sync_hdr_seen(sync_hdr_seen), .high_rate(high_rate), .carrier_sense(carrier_sense),
    .energy_level(energy_level), .measure_complete_event(measure_complete_event),
    .sync_detect_disable(sync_detect_disable), .radio_channel(radio_channel));

  task automatic finish_test();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic chk_in(input string name, input int lo, input int hi, input int got);
    n_checks++;
    if (got < lo || got > hi) begin
      failures++;
      $display("ERROR %s expected %0d..%0d seen %0d", name, lo, hi, got);
    end
  endtask

  // one classic cycle; request held until ack is sampled high
  task automatic wb(input logic we, input logic [7:0] adr, input logic [7:0] d,
                    output logic [7:0] rd);
    int i;
    i = 0;
    @(posedge sys_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_sel_i <= 4'hF;
    wb_dat_i <= {24'h000000, d};
    do begin
      @(posedge sys_clk);
      i++;
    end while (wb_ack_o !== 1'b1 && i < 20);
    if (i >= 20) begin
      chk("bus ack", 1, 0);
      finish_test();
    end
    rd = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask

  // bounded wait for the completion pulse, then its width
  task automatic wait_evt(input int lim, output int cnt);
    cnt = 0;
    while (measure_complete_event !== 1'b1) begin
      if (cnt >= lim) begin
        chk("event wait", 1, 0);
        finish_test();
      end
      @(posedge sys_clk);
      cnt++;
    end
    @(posedge sys_clk);
    chk("event width", 1'b0, measure_complete_event);
  endtask

  task automatic run(input logic [1:0] m, input int lo, input int hi, input logic idle_exp,
                     input bit clr);
    int c;
    logic [7:0] r;
    wb(1'b1, 8'h20, {1'b1, m, 5'h05}, r);
    if (clr) begin
      wb(1'b0, 8'h04, 8'h00, r);
      chk("status after request", {3'b000, radio_state}, r);
    end
    wait_evt(2000, c);
    chk_in("check duration", lo, hi, c);
    wb(1'b0, 8'h04, 8'h00, r);
    chk("status on completion", {1'b1, idle_exp, 1'b0, radio_state}, r);
  endtask

  task automatic sync_pulse();
    @(posedge sys_clk);
    sync_hdr_seen <= 1'b1;
    @(posedge sys_clk);
    sync_hdr_seen <= 1'b0;
  endtask

  task automatic new_frame(input logic hr);
    @(posedge sys_clk);
    rx_busy <= 1'b0;
    high_rate <= hr;
    @(posedge sys_clk);
    rx_busy <= 1'b1;
    sync_pulse();
  endtask

  initial begin
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    chk("channel out", 5'h0B, radio_channel);
    chk("sync disable out", 1'b0, sync_detect_disable);
    wb(1'b0, 8'h04, 8'h00, q);
    chk("status reset", 8'h00, q);
    wb(1'b0, 8'h20, 8'h00, q);
    chk("ctrl reset", 8'h2B, q);
    wb(1'b0, 8'h24, 8'h00, q);
    chk("thres reset", 8'hC7, q);
    wb(1'b0, 8'h40, 8'h00, q);
    chk("unmapped read", 8'h00, q);
    wb(1'b1, 8'h04, 8'hFF, q);
    wb(1'b0, 8'h04, 8'h00, q);
    chk("status read only", 8'h00, q);
    // channel write alone must not launch a check
    wb(1'b1, 8'h20, 8'h05, q);
    chk("channel out", 5'h05, radio_channel);
    n = 0;
    repeat (30) begin
      @(posedge sys_clk);
      if (measure_complete_event !== 1'b0) n++;
    end
    chk("no event without start", 0, n);
    radio_state <= 5'h16;
    rx_listening <= 1'b1;
    foreach (rows[k]) begin
      wb(1'b1, 8'h24, {4'hC, rows[k].thr}, q);
      energy_level <= rows[k].energy;
      carrier_sense <= rows[k].cs;
      run(rows[k].mode, 1270, assess_pkg::RESULT_LIMIT_CYCLES, rows[k].idle, 1);
    end
    // outside receive: completes at once, reported busy
    rx_listening <= 1'b0;
    radio_state <= 5'h08;
    energy_level <= 8'h00;
    carrier_sense <= 1'b0;
    run(2'h1, 0, 8, 1'b0, 0);
    wb(1'b0, 8'h20, 8'h00, q);
    chk("start reads zero", 8'h25, q);
    // frame: a request inside the automatic window waits for its end unless in mode 2
    radio_state <= 5'h11;
    new_frame(1'b0);
    run(2'h1, 1260, 1290, 1'b1, 0);
    sync_pulse();
    run(2'h1, 0, 8, 1'b1, 0);
    new_frame(1'b1);
    run(2'h3, 300, 330, 1'b1, 0);
    new_frame(1'b0);
    carrier_sense <= 1'b1;
    run(2'h2, 0, 8, 1'b0, 0);
    // mode 0 lands inside the still running automatic window, so it waits for its end
    run(2'h0, 1260, 1290, 1'b0, 0);
    // sync disable keeps the receiver listening
    wb(1'b1, 8'h54, 8'h80, q);
    chk("sync disable out", 1'b1, sync_detect_disable);
    new_frame(1'b0);
    run(2'h2, 1270, assess_pkg::RESULT_LIMIT_CYCLES, 1'b0, 1);
    wb(1'b1, 8'h54, 8'h00, q);
    chk("sync disable out", 1'b0, sync_detect_disable);
    // reset in the middle of a listening check drops it and clears everything
    rx_busy <= 1'b0;
    rx_listening <= 1'b1;
    wb(1'b1, 8'h20, 8'hA5, q);
    repeat (20) @(posedge sys_clk);
    rst <= 1'b1;
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    n = 0;
    repeat (1400) begin
      @(posedge sys_clk);
      if (measure_complete_event !== 1'b0) n++;
    end
    chk("no event after reset", 0, n);
    wb(1'b0, 8'h04, 8'h00, q);
    chk("status after reset", {3'b000, radio_state}, q);
    wb(1'b0, 8'h20, 8'h00, q);
    chk("ctrl after reset", 8'h2B, q);
    finish_test();
  end
endmodule
